// >>> rtl/opfm_pkg.sv
// Package for the output protection and fault manager: constants and carriers
package opfm_pkg;

    // Clock rate in MHz
    localparam int CLK_MHZ = 40;
    // Over/under voltage mask after a reference change, in microseconds
    localparam int MASK_US = 67;
    // Raised overcurrent threshold hold after a reference change, in microseconds
    localparam int BOOST_US = 15;
    // Cycle counts derived from the times above
    localparam logic [11:0] MASK_CYC = 12'(MASK_US * CLK_MHZ);
    localparam logic [9:0] BOOST_CYC = 10'(BOOST_US * CLK_MHZ);

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // Control field positions
    localparam int CTRL_OVP_FIXED = 0;
    localparam int CTRL_LEGACY = 1;
    localparam int CTRL_NPH_LO = 2;
    localparam int CTRL_PSI_TWO = 4;
    localparam int CTRL_W = 5;
    // Control reset value: tracking threshold, four phases, one phase in low power
    localparam logic [4:0] CTRL_RST = 5'h08;
    // Normal phase count codes
    localparam logic [1:0] NPH_TWO = 2'h0;
    localparam logic [1:0] NPH_THREE = 2'h1;
    // Phase enable masks
    localparam logic [3:0] EN_TWO = 4'h3;
    localparam logic [3:0] EN_THREE = 4'h7;
    localparam logic [3:0] EN_FOUR = 4'hf;
    localparam logic [3:0] EN_PSI_ONE = 4'h1;
    localparam logic [3:0] EN_PSI_TWO = 4'h5;

    // Comparator results from the analog front end
    typedef struct packed {
        logic uv;        // Sense more than 600 mV below reference
        logic ov_track;  // Sense above reference plus offset
        logic ov_pin;    // Sense above resistor-programmed level
        logic ov_1v8;    // Sense above fixed 1.800 V
        logic early_on;  // Sense above 1.800 V
        logic early_off; // Sense below 1.800 V minus 350 mV
        logic remote_ground_sense;       // Sense more than 500 mV above reference
        logic fb;        // Phase-one negative sense 700 mV above sense
        logic ref_chg;   // Dynamic reference change in progress
        logic ref_0p6;   // Ramping reference at or above 0.6 V
        logic [3:0] oc_nom;   // Per-phase current over programmed threshold
        logic [3:0] oc_boost; // Per-phase current over 150 % threshold
    } opfm_cmp_s;

endpackage : opfm_pkg

// >>> rtl/opfm_top.sv
// Output protection and fault manager with APB control and status
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps

// Summary of operation
// - Mask OV/UV during reference change plus 67us
// - Protections stay active during soft-start ramp
// - UV trips after more than one period
// - UV trip: all switches off, phase4 high-Z
// - UV/OV latched until supply or enable cycles
// - Early clamp: low sides on, 350mV hysteresis
// - Early clamp drives only phases one-three
// - OV latch: high off, low on, fault
// - Floating pin: tracking threshold, else fixed
// - Older code table uses fixed 1.800 V
// - Overcurrent: high off until recross or cycle
// - Sustained overcurrent ends at UV trip
// - 150% current threshold during change plus 15us
// - Low-power phase count from control register
// - Ground sense disconnect at 500 mV over
// - Feedback disconnect at 700 mV over
// - Disconnect faults latch all switches off
// - Enable low clears faults, all off unless early clamp active
// - UV enabled once reference reaches 0.6 V
module opfm_top
    import opfm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire opfm_cmp_s cmp,
    input wire logic cycle_start,
    input wire logic [3:0] pwm_req,
    input wire logic output_enable_pin,
    input wire logic supply_above_early,
    input wire logic supply_above_lockout,
    input wire logic low_power_state_input_n,
    input wire logic soft_start_done,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic [2:0] high_side_switch,
    output logic [2:0] low_side_switch,
    output logic fourth_phase_drive_out,
    output logic fourth_phase_drive_oe,
    output logic fault_indicator_pin,
    output logic soft_start_done_out
);

    // Whole module state
    typedef struct packed {
        opfm_cmp_s sync1;       // First synchroniser stage
        opfm_cmp_s sync2;       // Second synchroniser stage
        logic [11:0] mask_cnt;  // Voltage check mask countdown
        logic [9:0] boost_cnt;  // Raised current threshold countdown
        logic uv_armed;         // Undervoltage seen at last period start
        logic uv_lat;           // Undervoltage trip latch
        logic ov_lat;           // Overvoltage trip latch
        logic fbg_lat;          // Ground sense disconnect latch
        logic fb_lat;           // Feedback disconnect latch
        logic clamp;            // Early overvoltage clamp active
        logic [3:0] oc_hold;    // Per-phase current limit active
        logic [CTRL_W-1:0] ctrl; // Control register
        logic [2:0] hs;         // High-side drives
        logic [2:0] ls;         // Low-side drives
        logic p4_out;           // Fourth phase drive level
        logic p4_oe;            // Fourth phase drive enable
        logic fault;            // Fault pin
        logic ss_done;          // Soft-start done output
        logic pready;           // APB ready
        logic [31:0] prdata;    // APB read data
        logic pslverr;          // APB error
    } opfm_state_s;

    opfm_state_s q; // Registered state
    opfm_state_s next_q; // Next state
    opfm_cmp_s c; // Synchronised comparator view
    logic run; // Supply above lockout and enabled
    logic masked; // Voltage checks masked
    logic boost; // Raised current threshold in use
    logic [3:0] en; // Phases enabled
    logic [3:0] next_hold; // Next per-phase limit state
    logic [3:0] ph_hs; // Per-phase high-side demand
    logic [3:0] ph_ls; // Per-phase low-side demand

    assign c = q.sync2;
    assign run = supply_above_lockout & output_enable_pin;
    assign masked = c.ref_chg | (q.mask_cnt != 12'h000);
    assign boost = c.ref_chg | (q.boost_cnt != 10'h000);

    // Phase enable from phase count and low-power input
    always_comb begin
        unique case (q.ctrl[CTRL_NPH_LO +: 2])
            NPH_TWO: en = EN_TWO;
            NPH_THREE: en = EN_THREE;
            default: en = EN_FOUR;
        endcase
        if (!low_power_state_input_n && !c.ref_chg) begin
            // Two phases only allowed with three or four normal phases
            if (q.ctrl[CTRL_PSI_TWO] && q.ctrl[CTRL_NPH_LO +: 2] != NPH_TWO) begin
                en = EN_PSI_TWO;
            end else begin
                en = EN_PSI_ONE;
            end
        end
    end

    // Per-phase cycle-by-cycle current limit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_phase
            logic oc_sel; // Threshold chosen for this phase
            assign oc_sel = boost ? c.oc_boost[gi] : c.oc_nom[gi];
            // hold until recross or next period
            assign next_hold[gi] = !cycle_start & oc_sel & (pwm_req[gi] | q.oc_hold[gi]);
            assign ph_hs[gi] = en[gi] & pwm_req[gi] & !next_hold[gi];
            assign ph_ls[gi] = en[gi] & (!pwm_req[gi] | next_hold[gi]);
        end
    endgenerate

    // Next-state logic
    always_comb begin
        logic ov_hit; // Selected overvoltage comparison
        logic uv_en; // Qualified undervoltage condition
        ov_hit = 1'b0;
        uv_en = 1'b0;
        next_q = q;
        next_q.sync1 = cmp;
        next_q.sync2 = q.sync1;
        // reload while changing, count down after
        if (c.ref_chg) begin
            next_q.mask_cnt = MASK_CYC;
        end else if (q.mask_cnt != 12'h000) begin
            next_q.mask_cnt = q.mask_cnt - 12'h001;
        end
        // reload while changing, count down after
        if (c.ref_chg) begin
            next_q.boost_cnt = BOOST_CYC;
        end else if (q.boost_cnt != 10'h000) begin
            next_q.boost_cnt = q.boost_cnt - 10'h001;
        end
        next_q.oc_hold = next_hold;

        if (q.ctrl[CTRL_LEGACY]) begin
            ov_hit = c.ov_1v8;
        end else if (q.ctrl[CTRL_OVP_FIXED]) begin
            ov_hit = c.ov_pin;
        end else begin
            ov_hit = c.ov_track;
        end
        // undervoltage waits for 0.6 V reference
        uv_en = !masked & c.ref_0p6 & c.uv;

        // disable or lockout clears every latch
        if (!run) begin
            next_q.uv_armed = 1'b0;
            next_q.uv_lat = 1'b0;
            next_q.ov_lat = 1'b0;
            next_q.fbg_lat = 1'b0;
            next_q.fb_lat = 1'b0;
        end else begin
            if (!masked && ov_hit) begin
                next_q.ov_lat = 1'b1;
            end
            // must persist across a full period
            if (!uv_en) begin
                next_q.uv_armed = 1'b0;
            end else if (cycle_start) begin
                next_q.uv_armed = 1'b1;
                if (q.uv_armed) begin
                    next_q.uv_lat = 1'b1;
                end
            end
            if (c.remote_ground_sense) begin
                next_q.fbg_lat = 1'b1;
            end
            if (c.fb) begin
                next_q.fb_lat = 1'b1;
            end
        end

        if (supply_above_early && !supply_above_lockout) begin
            if (c.early_on) begin
                next_q.clamp = 1'b1;
            end else if (c.early_off) begin
                next_q.clamp = 1'b0;
            end
        end else begin
            next_q.clamp = 1'b0;
        end

        // Default drive: all off, fourth phase released
        next_q.hs = 3'h0;
        next_q.ls = 3'h0;
        next_q.p4_out = 1'b0;
        next_q.p4_oe = 1'b0;
        if (next_q.ov_lat) begin
            // low sides on, fourth phase low
            next_q.ls = 3'h7;
            next_q.p4_oe = 1'b1;
        end else if (next_q.clamp) begin
            next_q.ls = 3'h7;
        end else if (run && !next_q.uv_lat && !next_q.fbg_lat && !next_q.fb_lat) begin
            // Normal switching with current limit
            next_q.hs = ph_hs[2:0];
            next_q.ls = ph_ls[2:0];
            next_q.p4_out = ph_hs[3];
            next_q.p4_oe = en[3];
        end
        // undervoltage falls through to all off
        // disconnects fall through to all off
        next_q.fault = next_q.uv_lat | next_q.ov_lat | next_q.fbg_lat | next_q.fb_lat;
        // done output held low while disabled
        next_q.ss_done = output_enable_pin & soft_start_done;

        // APB slave, one wait state
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            next_q.pready = 1'b1;
            next_q.prdata = 32'h0;
            if (paddr == CTRL_OFS) begin
                // Control read/write
                if (pwrite) begin
                    next_q.ctrl = pwdata[CTRL_W-1:0];
                end else begin
                    next_q.prdata = {27'h0, q.ctrl};
                end
            end else if (paddr == STATUS_OFS) begin
                // Status read, writes ignored
                if (!pwrite) begin
                    next_q.prdata = {24'h0, boost, masked, q.clamp, q.fb_lat,
                                     q.fbg_lat, q.ov_lat, q.uv_lat, q.fault};
                end
            end else begin
                // Unmapped address
                next_q.pslverr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flops
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign high_side_switch = q.hs;
    assign low_side_switch = q.ls;
    assign fourth_phase_drive_out = q.p4_out;
    assign fourth_phase_drive_oe = q.p4_oe;
    assign fault_indicator_pin = q.fault;
    assign soft_start_done_out = q.ss_done;

    a_uv_all_off: assert property (@(posedge clk) disable iff (reset)
        (q.uv_lat && !q.ov_lat) |-> (q.hs == 3'h0 && q.ls == 3'h0 && !q.p4_oe && q.fault))
        else $error("undervoltage trip left a switch on");

    a_ov_low_on: assert property (@(posedge clk) disable iff (reset)
        q.ov_lat |-> (q.hs == 3'h0 && q.ls == 3'h7 && q.p4_oe && !q.p4_out && q.fault))
        else $error("overvoltage trip drive wrong");

    a_mask_blocks_uv: assert property (@(posedge clk) disable iff (reset)
        (masked && !q.uv_lat) |=> !q.uv_lat)
        else $error("undervoltage latched while masked");

    a_mask_reload: assert property (@(posedge clk) disable iff (reset)
        c.ref_chg |=> q.mask_cnt == MASK_CYC)
        else $error("mask counter not reloaded");

    a_boost_length: assert property (@(posedge clk) disable iff (reset)
        $fell(c.ref_chg) |-> q.boost_cnt == BOOST_CYC)
        else $error("boost hold not started at full length");

    a_fault_latched: assert property (@(posedge clk) disable iff (reset)
        (q.fault && run) |=> q.fault)
        else $error("fault released without cycling");

    a_enable_clears: assert property (@(posedge clk) disable iff (reset)
        !output_enable_pin |=> (!q.fault && !q.ss_done && q.hs == 3'h0))
        else $error("disable did not clear");

    // early clamp leaves fourth phase released
    a_clamp_no_p4: assert property (@(posedge clk) disable iff (reset)
        q.clamp |-> (q.ls == 3'h7 && !q.p4_oe && q.hs == 3'h0))
        else $error("early clamp drive wrong");

    // limited phase keeps high side off
    a_oc_hs_off: assert property (@(posedge clk) disable iff (reset)
        (q.oc_hold != 4'h0) |-> ((q.hs & q.oc_hold[2:0]) == 3'h0))
        else $error("high side on while current limited");

    a_uv_needs_ref: assert property (@(posedge clk) disable iff (reset)
        (!c.ref_0p6 && !q.uv_lat) |=> !q.uv_lat)
        else $error("undervoltage before reference at 0.6 V");

    // disconnect faults hold all switches off
    a_disc_all_off: assert property (@(posedge clk) disable iff (reset)
        ((q.fbg_lat || q.fb_lat) && !q.ov_lat)
        |-> (q.hs == 3'h0 && q.ls == 3'h0 && !q.p4_oe && q.fault))
        else $error("disconnect fault left a switch on");

    // clamp only inside its supply window
    a_clamp_window: assert property (@(posedge clk) disable iff (reset)
        q.clamp |-> $past(supply_above_early && !supply_above_lockout))
        else $error("early clamp outside its supply window");

endmodule // opfm_top

// >>> bench/opfm_power_stage.sv
// Behavioural model of the power stages and external phase driver
`timescale 1ns/1ps
module opfm_power_stage
    import opfm_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] high_side_switch,
    input wire logic [2:0] low_side_switch,
    input wire logic fourth_phase_drive_out,
    input wire logic fourth_phase_drive_oe,
    output logic p4_line,
    output logic load_floating,
    output logic shoot_through
);
    logic p4_last = 1'b0; // Last level driven onto the phase four line

    // released line shows the inverse of the last driven level
    always_comb begin
        p4_line = fourth_phase_drive_oe ? fourth_phase_drive_out : ~p4_last;
        load_floating = (high_side_switch == 3'h0) && (low_side_switch == 3'h0)
            && !fourth_phase_drive_oe;
        shoot_through = |(high_side_switch & low_side_switch);
    end

    // Remember the driven level while the line is held
    always @(posedge clk) begin
        if (fourth_phase_drive_oe) begin
            p4_last <= fourth_phase_drive_out;
        end
    end
endmodule // opfm_power_stage

// >>> bench/tb.sv
// Self-checking testbench for the output protection and fault manager
`timescale 1ns/1ps
module tb
    import opfm_pkg::*;
;
    // One table row: settings, comparator levels, expected drives
    typedef struct packed {
        logic [4:0] ctrl;
        logic psi_n;
        logic ss;
        opfm_cmp_s cmp;
        logic full;
        logic [8:0] exp; // hs, ls, oe, out, fault
    } opfm_row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    opfm_cmp_s cmp = '0;
    logic cycle_start = 1'b0;
    logic [3:0] pwm_req = 4'hf;
    logic output_enable_pin = 1'b0;
    logic supply_above_early = 1'b1;
    logic supply_above_lockout = 1'b1;
    logic low_power_state_input_n = 1'b1;
    logic soft_start_done = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, fourth_phase_drive_out, fourth_phase_drive_oe;
    logic fault_indicator_pin, soft_start_done_out, p4_line, load_floating, shoot_through;
    logic [31:0] prdata;
    logic [2:0] high_side_switch, low_side_switch;
    int mismatches = 0;
    int compares = 0;
    logic [2:0] ph = 3'h0; // Position within the switching period
    logic [31:0] rd; // Last read data
    logic err; // Last error response
    opfm_row_s rows [15];
    opfm_cmp_s c;

    opfm_top uut (.clk, .reset, .cmp, .cycle_start, .pwm_req, .output_enable_pin,
        .supply_above_early, .supply_above_lockout, .low_power_state_input_n,
        .soft_start_done, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .high_side_switch, .low_side_switch, .fourth_phase_drive_out,
        .fourth_phase_drive_oe, .fault_indicator_pin, .soft_start_done_out);
    opfm_power_stage stage (.clk, .high_side_switch, .low_side_switch,
        .fourth_phase_drive_out, .fourth_phase_drive_oe, .p4_line, .load_floating,
        .shoot_through);

    // Clock generator
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Switching period start pulse every eight cycles
    always @(posedge clk) begin
        ph <= ph + 3'h1;
        cycle_start <= (ph == 3'h7);
    end
    // Verdict and end of run
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare switch drives and fault pin
    task automatic outs(input logic [8:0] e, input logic full);
        if (full) begin
            chk(32'({high_side_switch, low_side_switch, fourth_phase_drive_oe,
                fourth_phase_drive_oe & p4_line, fault_indicator_pin}), 32'(e));
        end else begin
            chk(32'({high_side_switch, fault_indicator_pin}), 32'({e[8:6], e[0]}));
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Wait, then align to a fixed point of the period
    task automatic settle(input int n);
        cyc(n);
        while (ph != 3'h4) @(posedge clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
    endtask
    // Comparator levels with quiet defaults
    function automatic opfm_cmp_s mkc(input logic [5:0] b, input logic r);
        opfm_cmp_s v;
        v = '0;
        {v.uv, v.ov_track, v.ov_pin, v.ov_1v8, v.remote_ground_sense, v.fb} = b;
        v.early_off = 1'b1;
        v.ref_0p6 = r;
        return v;
    endfunction
    // Watchdog against hangs
    initial begin
        cyc(20000);
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial begin
        rows[0] = '{5'h08, 1'b1, 1'b1, mkc(6'h00, 1'b1), 1'b1, 9'h1c6};
        rows[1] = '{5'h00, 1'b1, 1'b1, mkc(6'h00, 1'b1), 1'b1, 9'h0c0};
        rows[2] = '{5'h08, 1'b0, 1'b1, mkc(6'h00, 1'b1), 1'b0, 9'h040};
        rows[3] = '{5'h18, 1'b0, 1'b1, mkc(6'h00, 1'b1), 1'b0, 9'h140};
        rows[4] = '{5'h10, 1'b0, 1'b1, mkc(6'h00, 1'b1), 1'b0, 9'h040};
        rows[5] = '{5'h08, 1'b1, 1'b1, mkc(6'h10, 1'b1), 1'b1, 9'h03d};
        rows[6] = '{5'h08, 1'b1, 1'b1, mkc(6'h08, 1'b1), 1'b0, 9'h1c0};
        rows[7] = '{5'h09, 1'b1, 1'b1, mkc(6'h08, 1'b1), 1'b1, 9'h03d};
        rows[8] = '{5'h0a, 1'b1, 1'b1, mkc(6'h04, 1'b1), 1'b1, 9'h03d};
        rows[9] = '{5'h08, 1'b1, 1'b1, mkc(6'h20, 1'b1), 1'b1, 9'h001};
        rows[10] = '{5'h08, 1'b1, 1'b1, mkc(6'h20, 1'b0), 1'b0, 9'h1c0};
        rows[11] = '{5'h08, 1'b1, 1'b1, mkc(6'h02, 1'b1), 1'b1, 9'h001};
        rows[12] = '{5'h08, 1'b1, 1'b1, mkc(6'h01, 1'b1), 1'b1, 9'h001};
        rows[13] = '{5'h08, 1'b1, 1'b1, mkc(6'h30, 1'b1), 1'b1, 9'h03d};
        rows[14] = '{5'h08, 1'b1, 1'b0, mkc(6'h10, 1'b1), 1'b1, 9'h03d};
        cyc(12);
        chk(32'({high_side_switch, low_side_switch, fault_indicator_pin, pready}), 0);
        reset <= 1'b0;
        apb(1'b0, CTRL_OFS, 0);
        chk(rd, 32'h08);
        apb(1'b0, 8'h10, 0);
        chk(32'(err), 1);
        chk(rd, 0);
        apb(1'b1, STATUS_OFS, 32'hff);
        apb(1'b0, CTRL_OFS, 0);
        chk(rd, 32'h08);
        $display("register test done");
        // Table of ordinary cases
        for (int i = 0; i < 15; i++) begin
            output_enable_pin <= 1'b0;
            apb(1'b1, CTRL_OFS, 32'(rows[i].ctrl));
            low_power_state_input_n <= rows[i].psi_n;
            soft_start_done <= rows[i].ss;
            cmp <= rows[i].cmp;
            output_enable_pin <= 1'b1;
            settle(40);
            outs(rows[i].exp, rows[i].full);
            chk(32'(soft_start_done_out), 32'(rows[i].ss));
            if (rows[i].exp[0]) begin
                cmp <= mkc(6'h00, 1'b1);
                settle(10);
                chk(32'(fault_indicator_pin), 1);
            end
            output_enable_pin <= 1'b0;
            cyc(4);
            chk(32'({high_side_switch, low_side_switch, fourth_phase_drive_oe,
                fault_indicator_pin, soft_start_done_out, load_floating}), 1);
            $display("row %0d done", i);
        end
        // Status flags after an overvoltage latch
        cmp <= mkc(6'h10, 1'b1);
        output_enable_pin <= 1'b1;
        settle(40);
        apb(1'b0, STATUS_OFS, 0);
        chk(32'(err), 0);
        chk(rd, 32'h05);
        // Current limit, then undervoltage stops all
        output_enable_pin <= 1'b0;
        c = mkc(6'h00, 1'b1);
        c.oc_nom[0] = 1'b1;
        cmp <= c;
        cyc(4);
        output_enable_pin <= 1'b1;
        settle(20);
        chk(32'({high_side_switch, low_side_switch}), 32'h31);
        c.uv = 1'b1;
        cmp <= c;
        settle(30);
        outs(9'h001, 1'b1);
        $display("overcurrent test done");
        // Raised current threshold and masking around a reference change
        output_enable_pin <= 1'b0;
        c = mkc(6'h00, 1'b1);
        c.ref_chg = 1'b1;
        c.oc_nom[1] = 1'b1;
        cmp <= c;
        cyc(4);
        output_enable_pin <= 1'b1;
        settle(20);
        chk(32'(high_side_switch), 32'h7);
        c.oc_boost[1] = 1'b1;
        c.ov_track = 1'b1;
        cmp <= c;
        settle(20);
        chk(32'({high_side_switch, low_side_switch, fault_indicator_pin}), 32'h54);
        c = mkc(6'h10, 1'b1);
        cmp <= c;
        cyc(2600);
        chk(32'(fault_indicator_pin), 0);
        cyc(120);
        chk(32'(fault_indicator_pin), 1);
        $display("reference change test done");
        // Early clamp below lockout with hysteresis
        output_enable_pin <= 1'b0;
        supply_above_lockout <= 1'b0;
        c = mkc(6'h00, 1'b1);
        c.early_on = 1'b1;
        c.early_off = 1'b0;
        cmp <= c;
        cyc(4);
        output_enable_pin <= 1'b1;
        settle(20);
        chk(32'({high_side_switch, low_side_switch, fourth_phase_drive_oe}), 32'h0e);
        c.early_on = 1'b0;
        cmp <= c;
        settle(20);
        chk(32'(low_side_switch), 32'h7);
        c.early_off = 1'b1;
        cmp <= c;
        settle(20);
        chk(32'(low_side_switch), 32'h0);
        chk(32'(shoot_through), 0);
        // Supply below the early threshold: no clamp at all
        c.early_on = 1'b1;
        c.early_off = 1'b0;
        cmp <= c;
        supply_above_early <= 1'b0;
        settle(20);
        chk(32'(low_side_switch), 32'h0);
        $display("clamp test done");
        wrap_up();
    end
endmodule // tb
